//--- trace_debug_pkg.sv
// Package of constants, encodings and reset values for the breakpoint and trace block.
package trace_debug_pkg;
  // ------------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------------
  localparam int ADDR_W     = 16;  // CPU address width.
  localparam int DATA_W     = 8;   // CPU data width.
  localparam int FIFO_DEPTH = 8;   // Trace FIFO stages.
  localparam int NUM_W      = 4;   // Valid count width, 1:0:0:0 is full.
  localparam int PIPE_SKIP  = 2;   // Bus cycles after a begin trigger with no capture.

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [NUM_W-1:0]  NUM_ZERO  = 4'h0;
  localparam logic [NUM_W-1:0]  NUM_ONE   = 4'h1;
  localparam logic [NUM_W-1:0]  NUM_FULL  = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [1:0]        SKIP_INIT = 2'h2;

  // ------------------------------------------------------------------
  // Trigger modes
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_A_ONLY       = 4'h0,
    MODE_A_OR_B       = 4'h1,
    MODE_A_THEN_B     = 4'h2,
    MODE_EVENT_B      = 4'h3,
    MODE_A_THEN_EV_B  = 4'h4,
    MODE_A_AND_B_DATA = 4'h5,
    MODE_A_NOT_B_DATA = 4'h6,
    MODE_INSIDE       = 4'h7,
    MODE_OUTSIDE      = 4'h8
  } trig_mode_type;

  // Run states, one-hot.
  typedef enum logic [2:0] {
    RUN_IDLE    = 3'b001,
    RUN_WAIT    = 3'b010,
    RUN_CAPTURE = 3'b100
  } run_state_type;
endpackage

//--- opcode_tracker.sv
// Opcode tracker that follows a tagged fetch through the instruction queue.
`timescale 1ns/1ps
module opcode_tracker #(
  parameter int DEPTH = 4
) (
  input  wire logic clock,         // Bus clock.
  input  wire logic rst_b,         // Synchronous reset, active low.
  input  wire logic fetch_tag,     // Match seen on an opcode fetch.
  input  wire logic opcode_fetch,  // An opcode enters the queue.
  input  wire logic opcode_exec,   // The oldest queued opcode executes.
  input  wire logic queue_flush,   // Change of flow discards the queue.
  output logic      exec_hit       // Tagged opcode executed, one-cycle pulse.
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0] tags_ff;  // Tag bit per queue slot, bit 0 is oldest.
    logic             hit_ff;   // Registered execute hit.
  } trk_type;

  trk_type cur_ff;
  trk_type nxt_cur;

  assign exec_hit = cur_ff.hit_ff;

  // Shift out on execute, append on fetch; a flush drops every tag so
  // opcodes thrown away never trigger.
  always_comb
  begin
    logic [DEPTH-1:0] t;
    t = cur_ff.tags_ff;
    nxt_cur = cur_ff;
    nxt_cur.hit_ff = opcode_exec & t[0];
    if (opcode_exec)
    begin
      t = t >> 1;
    end
    if (queue_flush)
    begin
      t = '0;
    end
    else if (opcode_fetch)
    begin
      t[DEPTH-1] = fetch_tag;
    end
    nxt_cur.tags_ff = t;
  end

  // Register the state.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end
endmodule

//--- debug_breakpoint_trace_fifo.sv
// Background breakpoint and trace FIFO with comparators and trigger logic.
//
// Summary of operation
// - Breakpoint compares every address to match register.
// - Forced type breaks after any match access.
// - Tagged type marks opcode, breaks on execution.
// - Enable resets zero; zero blocks both simple breakpoint types.
// - Select one forces, zero tags.
// - Eight-stage FIFO stores address or data.
// - Two comparators, each with read/write qualify.
// - Opcode tracking triggers only on execution; inside/outside range modes ignore it.
// - Magnitude compares give inside/outside range triggers.
// - Comparators suppressed during debug controller accesses.
// - A compares address; B address or data.
// - Write qualify selects write data, else read.
// - Match breaks, stores data, starts or stops.
// - Count valid words; host skips unused entries.
// - High byte then low; low shifts.
// - Event modes store byte; low read shifts.
// - Change of flow near begin trigger dropped.
// - End trigger change of flow stored last.
// - Unarmed low reads push last opcode address.
// - Store taken conditional branch source only.
// - Indirect jumps, interrupts, returns store destination.
// - Registers reachable by user and debug port.
// - Arm sets flag, clears flags, count.
// - Begin ends full; end ends on trigger.
`timescale 1ns/1ps
module debug_breakpoint_trace_fifo #(
  parameter int ADDR_W = trace_debug_pkg::ADDR_W,
  parameter int DATA_W = trace_debug_pkg::DATA_W
) (
  input  wire logic              clock,                     // Bus clock, 100 MHz.
  input  wire logic              rst_b,                     // Synchronous reset, active low.
  input  wire logic [ADDR_W-1:0] cpu_addr,                  // CPU address bus.
  input  wire logic [DATA_W-1:0] cpu_wdata,                 // CPU write data bus.
  input  wire logic [DATA_W-1:0] cpu_rdata,                 // CPU read data bus.
  input  wire logic              cpu_read,                  // High on read cycles.
  input  wire logic              cpu_valid,                 // A bus cycle happens.
  input  wire logic              bgd_access,                // Cycle made for the debug port.
  input  wire logic              opcode_fetch,              // Cycle fetches an opcode.
  input  wire logic              opcode_exec,               // Oldest queued opcode executes.
  input  wire logic              queue_flush,               // Queue thrown away.
  input  wire logic              cof_valid,                 // Change of flow to record.
  input  wire logic [ADDR_W-1:0] cof_addr,                  // Address the CPU picked for it.
  input  wire logic              instr_boundary,            // Instruction boundary.
  input  wire logic [ADDR_W-1:0] breakpoint_match_address,  // Breakpoint match value.
  input  wire logic              breakpoint_enable,         // Breakpoint enable.
  input  wire logic              force_tag_select,          // 1 force, 0 tag.
  input  wire logic              trace_module_enable,       // Trace enable.
  input  wire logic              arm_write,                 // Pulse: arm control written.
  input  wire logic              arm_value,                 // Value written to arm.
  input  wire logic              enable_write,              // Pulse: enable written.
  input  wire logic [3:0]        trig_mode,                 // Trigger mode.
  input  wire logic              begin_type,                // 1 begin trace, 0 end trace.
  input  wire logic              trig_opcode_sel,           // 1 opcode tracked triggers.
  input  wire logic              brk_enable,                // Trace breakpoint enable.
  input  wire logic              brk_tag,                   // Trace breakpoint tag type.
  input  wire logic [ADDR_W-1:0] comp_a_value,              // Comparator A value.
  input  wire logic [ADDR_W-1:0] comp_b_value,              // Comparator B value.
  input  wire logic              comp_a_rw_qualify_enable,  // A qualify enable.
  input  wire logic              comp_a_rw_value,           // A read/write value, 1 read.
  input  wire logic              comp_b_rw_qualify_enable,  // B qualify enable.
  input  wire logic              comp_b_rw_value,           // B read/write value, 1 read.
  input  wire logic              fifo_high_read,            // Pulse: high byte port read.
  input  wire logic              fifo_low_read,             // Pulse: low byte port read.
  output logic                   force_break,               // Force request to CPU.
  output logic                   tag_break,                 // Tag for fetched opcode.
  output logic [DATA_W-1:0]      fifo_high_byte_port,       // FIFO high byte.
  output logic [DATA_W-1:0]      fifo_low_byte_port,        // FIFO low byte.
  output logic [3:0]             fifo_valid_count,          // Valid words.
  output logic                   armed_flag,                // Run armed.
  output logic                   comp_a_match_flag,         // A matched this run.
  output logic                   comp_b_match_flag          // B matched this run.
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  localparam int DEPTH = trace_debug_pkg::FIFO_DEPTH;

  typedef struct packed {
    logic [DEPTH-1:0][ADDR_W-1:0]   fifo_ff;    // Entry 0 is the output port.
    logic [3:0]                     num_ff;     // Valid words.
    trace_debug_pkg::run_state_type run_ff;     // Run state.
    logic                           armed_ff;   // Armed flag.
    logic                           am_ff;      // A match flag.
    logic                           bm_ff;      // B match flag.
    logic                           a_seen_ff;  // A has matched, for then-modes.
    logic [1:0]                     skip_ff;    // Cycles of begin pipeline skip.
    logic                           force_ff;   // Pending force request.
    logic                           tag_ff;     // Registered tag output.
    logic [ADDR_W-1:0]              last_op_ff; // Last fetched opcode address.
    logic [DATA_W-1:0]              hi_ff;      // Registered high port.
    logic [DATA_W-1:0]              lo_ff;      // Registered low port.
  } st_type;

  st_type cur_ff;
  st_type nxt_cur;

  // ------------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------------
  trace_debug_pkg::trig_mode_type mode;
  logic              qual_ok;   // Cycle may be compared.
  logic              rw_a_ok;   // Read/write qualify for A.
  logic              rw_b_ok;   // Read/write qualify for B.
  logic              a_hit;     // Address equals A.
  logic              b_hit;     // Address equals B.
  logic              d_hit;     // Data equals low half of B.
  logic [DATA_W-1:0] cmp_data;  // Data bus chosen for B.
  logic              a_exec;    // Tracked A hit.
  logic              b_exec;    // Tracked B hit.
  logic              a_ev;      // Qualified A event.
  logic              b_ev;      // Qualified B event.
  logic              bkpt_hit;  // Simple breakpoint match.

  assign mode = trace_debug_pkg::trig_mode_type'(trig_mode);
  assign qual_ok = cpu_valid & ~bgd_access;
  assign rw_a_ok = ~comp_a_rw_qualify_enable | (cpu_read == comp_a_rw_value);
  assign rw_b_ok = ~comp_b_rw_qualify_enable | (cpu_read == comp_b_rw_value);
  // Write data only when A is qualified to write cycles.
  assign cmp_data = (comp_a_rw_qualify_enable & ~comp_a_rw_value) ? cpu_wdata
                                                                  : cpu_rdata;
  assign a_hit = qual_ok & rw_a_ok & (cpu_addr == comp_a_value);
  assign b_hit = qual_ok & rw_b_ok & (cpu_addr == comp_b_value);
  assign d_hit = cmp_data == comp_b_value[DATA_W-1:0];
  assign bkpt_hit = breakpoint_enable & cpu_valid
                    & (cpu_addr == breakpoint_match_address);

  // Each comparator has its own tracker so two tags can be in flight.
  opcode_tracker #(.DEPTH(4)) trk_a (
    .clock        (clock),
    .rst_b        (rst_b),
    .fetch_tag    (a_hit & opcode_fetch),
    .opcode_fetch (opcode_fetch),
    .opcode_exec  (opcode_exec),
    .queue_flush  (queue_flush),
    .exec_hit     (a_exec)
  );
  opcode_tracker #(.DEPTH(4)) trk_b (
    .clock        (clock),
    .rst_b        (rst_b),
    .fetch_tag    (b_hit & opcode_fetch),
    .opcode_fetch (opcode_fetch),
    .opcode_exec  (opcode_exec),
    .queue_flush  (queue_flush),
    .exec_hit     (b_exec)
  );

  assign a_ev = trig_opcode_sel ? a_exec : a_hit;
  assign b_ev = trig_opcode_sel ? b_exec : b_hit;

  // ------------------------------------------------------------------
  // Trigger decode
  // ------------------------------------------------------------------
  logic event_mode;  // Data capture modes.
  logic trig;        // Qualified trigger this cycle.
  logic lo_range;    // Address at or above A.
  logic hi_range;    // Address at or below B.

  assign lo_range = cpu_addr >= comp_a_value;
  assign hi_range = cpu_addr <= comp_b_value;
  assign event_mode = (mode == trace_debug_pkg::MODE_EVENT_B)
                      | (mode == trace_debug_pkg::MODE_A_THEN_EV_B);

  // Mode decides which comparator pattern forms the trigger.
  always_comb
  begin
    case (mode)
      trace_debug_pkg::MODE_A_ONLY:       trig = a_ev;
      trace_debug_pkg::MODE_A_OR_B:       trig = a_ev | b_ev;
      trace_debug_pkg::MODE_A_THEN_B:     trig = b_ev & cur_ff.a_seen_ff;
      trace_debug_pkg::MODE_EVENT_B:      trig = b_ev;
      trace_debug_pkg::MODE_A_THEN_EV_B:  trig = b_ev & cur_ff.a_seen_ff;
      trace_debug_pkg::MODE_A_AND_B_DATA: trig = a_ev & d_hit;
      trace_debug_pkg::MODE_A_NOT_B_DATA: trig = a_ev & ~d_hit;
      trace_debug_pkg::MODE_INSIDE:       trig = qual_ok & lo_range & hi_range;
      trace_debug_pkg::MODE_OUTSIDE:      trig = qual_ok & ~(lo_range & hi_range);
      default:                            trig = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // One process handles arming, capture, shifting and breakpoints. A
  // shift on a low byte read and a push in the same cycle are merged so
  // no capture is lost.
  always_comb
  begin
    logic                         push;
    logic [ADDR_W-1:0]            pdata;
    logic                         stop;
    logic                         cof_ok;
    logic [DEPTH-1:0][ADDR_W-1:0] f;
    logic [3:0]                   c;
    push = 1'b0;
    pdata = trace_debug_pkg::ADDR_ZERO;
    stop = 1'b0;
    cof_ok = 1'b0;
    f = cur_ff.fifo_ff;
    c = cur_ff.num_ff;
    nxt_cur = cur_ff;
    if (opcode_fetch & cpu_valid)
    begin
      nxt_cur.last_op_ff = cpu_addr;
    end
    // Flags stay set until the next arm.
    if (cur_ff.armed_ff)
    begin
      nxt_cur.am_ff = cur_ff.am_ff | a_ev;
      nxt_cur.bm_ff = cur_ff.bm_ff | b_ev;
      nxt_cur.a_seen_ff = cur_ff.a_seen_ff | a_ev;
    end
    if (cur_ff.skip_ff != 2'h0)
    begin
      nxt_cur.skip_ff = cur_ff.skip_ff - 2'h1;
    end
    // Upstream only flags taken conditional branches, indirect jumps,
    // calls, interrupts and returns with the right address.
    cof_ok = cof_valid & ~event_mode;
    case (cur_ff.run_ff)
      trace_debug_pkg::RUN_WAIT:
      begin
        if (event_mode)
        begin
          if (trig)
          begin
            push = 1'b1;
            pdata = {{(ADDR_W-DATA_W){1'b0}}, cmp_data};
          end
        end
        else if (begin_type)
        begin
          if (trig)
          begin
            // The trigger's own change of flow is not captured.
            nxt_cur.run_ff = trace_debug_pkg::RUN_CAPTURE;
            nxt_cur.skip_ff = trace_debug_pkg::SKIP_INIT;
          end
        end
        else
        begin
          if (cof_ok)
          begin
            push = 1'b1;
            pdata = cof_addr;
          end
          stop = trig;
        end
      end
      trace_debug_pkg::RUN_CAPTURE:
      begin
        if (cof_ok & (cur_ff.skip_ff == 2'h0))
        begin
          push = 1'b1;
          pdata = cof_addr;
        end
      end
      default:
      begin
        // Unarmed: a low byte read samples the program counter.
        if (fifo_low_read)
        begin
          push = 1'b1;
          pdata = cur_ff.last_op_ff;
        end
      end
    endcase
    // Shift toward the port on a low byte read.
    if (fifo_low_read)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        f[i] = f[i+1];
      end
      f[DEPTH-1] = trace_debug_pkg::ADDR_ZERO;
      if (cur_ff.armed_ff & (c != trace_debug_pkg::NUM_ZERO))
      begin
        c = c - trace_debug_pkg::NUM_ONE;
      end
    end
    // Circular store: the newest word lands at the tail.
    if (push)
    begin
      // A read in this cycle has already made room at the tail.
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        f[i] = fifo_low_read ? f[i] : f[i+1];
      end
      f[DEPTH-1] = pdata;
      if (c != trace_debug_pkg::NUM_FULL)
      begin
        c = c + trace_debug_pkg::NUM_ONE;
      end
    end
    if (cur_ff.armed_ff & (begin_type | event_mode)
        & (c == trace_debug_pkg::NUM_FULL))
    begin
      stop = 1'b1;
    end
    nxt_cur.fifo_ff = f;
    nxt_cur.num_ff = c;
    if (stop)
    begin
      nxt_cur.run_ff = trace_debug_pkg::RUN_IDLE;
      nxt_cur.armed_ff = 1'b0;
    end
    // Manual stop by writing zero to arm or to enable.
    if ((arm_write & ~arm_value) | (enable_write & ~trace_module_enable))
    begin
      nxt_cur.run_ff = trace_debug_pkg::RUN_IDLE;
      nxt_cur.armed_ff = 1'b0;
    end
    else if (arm_write & arm_value & trace_module_enable)
    begin
      nxt_cur.run_ff = trace_debug_pkg::RUN_WAIT;
      nxt_cur.armed_ff = 1'b1;
      nxt_cur.am_ff = 1'b0;
      nxt_cur.bm_ff = 1'b0;
      nxt_cur.a_seen_ff = 1'b0;
      nxt_cur.num_ff = trace_debug_pkg::NUM_ZERO;
    end
    // Breakpoints: simple one and trace one. Full modes tag on A alone.
    nxt_cur.tag_ff = (bkpt_hit & ~force_tag_select & opcode_fetch)
                     | (brk_enable & brk_tag & cur_ff.armed_ff
                        & opcode_fetch & a_hit);
    if (instr_boundary)
    begin
      nxt_cur.force_ff = 1'b0;
    end
    if ((bkpt_hit & force_tag_select)
        | (brk_enable & ~brk_tag & cur_ff.armed_ff & trig))
    begin
      nxt_cur.force_ff = 1'b1;
    end
    if (!breakpoint_enable & !brk_enable)
    begin
      nxt_cur.force_ff = 1'b0;
    end
    nxt_cur.hi_ff = f[0][ADDR_W-1:DATA_W];
    nxt_cur.lo_ff = f[0][DATA_W-1:0];
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Reset clears breakpoint state and the count.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cur_ff <= '0;
      cur_ff.run_ff <= trace_debug_pkg::RUN_IDLE;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops; these ports serve both the user map
  // and the debug port.
  assign force_break = cur_ff.force_ff;
  assign tag_break = cur_ff.tag_ff;
  assign fifo_high_byte_port = cur_ff.hi_ff;
  assign fifo_low_byte_port = cur_ff.lo_ff;
  assign fifo_valid_count = cur_ff.num_ff;
  assign armed_flag = cur_ff.armed_ff;
  assign comp_a_match_flag = cur_ff.am_ff;
  assign comp_b_match_flag = cur_ff.bm_ff;
endmodule

//--- dbg_trace_properties.sv
// Concurrent checks on the ports of the breakpoint and trace block.
`timescale 1ns/1ps
module debug_trace_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_valid,
  input wire logic        bgd_access,
  input wire logic        opcode_fetch,
  input wire logic        instr_boundary,
  input wire logic [15:0] breakpoint_match_address,
  input wire logic        breakpoint_enable,
  input wire logic        force_tag_select,
  input wire logic        trace_module_enable,
  input wire logic        arm_write,
  input wire logic        arm_value,
  input wire logic        brk_enable,
  input wire logic        force_break,
  input wire logic        tag_break,
  input wire logic [3:0]  fifo_valid_count,
  input wire logic        armed_flag,
  input wire logic        comp_a_match_flag,
  input wire logic        comp_b_match_flag
);
  // --------------------------------------------------------------
  // Shared clocking and named steps
  // --------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // A user access that lands on the breakpoint address.
  sequence bkpt_hit_s;
    cpu_valid && !bgd_access && cpu_addr == breakpoint_match_address && breakpoint_enable;
  endsequence
  // A write of one to the arm control with the module enabled.
  sequence arm_s;
    arm_write && arm_value && trace_module_enable;
  endsequence
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  reset_clear_a: assert property (!$past(rst_b) |-> !force_break && !armed_flag
    && fifo_valid_count == 4'h0) else $error("outputs not clear after reset");
  force_hit_a: assert property (bkpt_hit_s ##0 (force_tag_select && !instr_boundary)
    |=> force_break) else $error("forced breakpoint missing");
  force_hold_a: assert property (force_break && !instr_boundary |=> force_break)
    else $error("forced request dropped early");
  tag_hit_a: assert property (bkpt_hit_s ##0 (!force_tag_select && opcode_fetch)
    |=> tag_break) else $error("tag missing on fetch");
  bkpt_off_a: assert property (!breakpoint_enable && !brk_enable |=> !tag_break)
    else $error("tag while disabled");
  arm_clear_a: assert property (arm_s |=> armed_flag && !comp_a_match_flag
    && !comp_b_match_flag && fifo_valid_count == 4'h0) else $error("arm did not clear");
  disarm_a: assert property (arm_write && !arm_value |=> !armed_flag)
    else $error("run not stopped");
  count_limit_a: assert property (fifo_valid_count <= 4'h8)
    else $error("count above full");
endmodule

//--- cpu_bus_model.sv
// Behavioural CPU core bus model driving the block's bus inputs.
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic  clock,
  output logic [15:0] cpu_addr,
  output logic [7:0]  cpu_wdata,
  output logic [7:0]  cpu_rdata,
  output logic        cpu_read,
  output logic        cpu_valid,
  output logic        bgd_access,
  output logic        opcode_fetch
);
  // ------------------------------------------------------------
  // Idle bus at time zero
  // ------------------------------------------------------------
  initial
  begin
    {cpu_addr, cpu_wdata, cpu_rdata} = 32'h0000_0000;
    {cpu_read, cpu_valid, bgd_access, opcode_fetch} = 4'h0;
  end
  // One bus cycle launched at a falling edge; the bus undriven data
  // side and the released address and data show inverted values, never stale ones.
  task automatic cycle(input logic [15:0] a, input logic rd, input logic [7:0] d,
                       input logic ftc, input logic bgd);
    @(negedge clock);
    cpu_addr = a;
    cpu_read = rd;
    cpu_rdata = rd ? d : ~d;
    cpu_wdata = rd ? ~d : d;
    cpu_valid = 1'b1;
    opcode_fetch = ftc;
    bgd_access = bgd;
    @(negedge clock);
    cpu_addr = ~a;
    cpu_rdata = ~cpu_rdata;
    cpu_wdata = ~cpu_wdata;
    {cpu_valid, opcode_fetch, bgd_access} = 3'h0;
  endtask
endmodule

//--- debug_breakpoint_trace_fifo_tb_top.sv
// Self-checking testbench for the breakpoint and trace block.
`timescale 1ns/1ps
module debug_breakpoint_trace_fifo_tb_top;
  logic        clock, cpu_read, cpu_valid, bgd_access, opcode_fetch;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, fifo_high_byte_port, fifo_low_byte_port;
  logic [15:0] cof_addr = 16'h0000, breakpoint_match_address = 16'h0000;
  logic [15:0] comp_a_value = 16'h0000, comp_b_value = 16'h0000;
  logic [3:0]  trig_mode = 4'h0, fifo_valid_count;
  logic        rst_b = 1'b0, opcode_exec = 1'b0, queue_flush = 1'b0, cof_valid = 1'b0;
  logic        instr_boundary = 1'b0, breakpoint_enable = 1'b0, force_tag_select = 1'b0;
  logic        trace_module_enable = 1'b0, arm_write = 1'b0, arm_value = 1'b0;
  logic        enable_write = 1'b0, begin_type = 1'b1, trig_opcode_sel = 1'b0;
  logic        brk_enable = 1'b0, brk_tag = 1'b0, fifo_high_read = 1'b0, fifo_low_read = 1'b0;
  logic        comp_a_rw_qualify_enable = 1'b0, comp_a_rw_value = 1'b0;
  logic        comp_b_rw_qualify_enable = 1'b0, comp_b_rw_value = 1'b0;
  logic        force_break, tag_break, armed_flag, comp_a_match_flag, comp_b_match_flag;
  int          n_fail = 0, checks_done = 0;
  debug_breakpoint_trace_fifo i_debug_breakpoint_trace_fifo (.*);
  cpu_bus_model i_cpu_bus_model (.*);
  // ------------------------------------------------------------
  // Clock, verdict and shared helpers
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Compare one seen value against its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle strobes, raised and lowered on falling edges.
  task automatic arm(input logic v);
    @(negedge clock);
    arm_write = 1'b1;
    arm_value = v;
    @(negedge clock);
    arm_write = 1'b0;
  endtask
  task automatic low_read();
    @(negedge clock);
    fifo_low_read = 1'b1;
    @(negedge clock);
    fifo_low_read = 1'b0;
  endtask
  task automatic boundary();
    @(negedge clock);
    instr_boundary = 1'b1;
    @(negedge clock);
    instr_boundary = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // The simple breakpoint: disabled, forced, then tagged.
  task automatic t_breakpoint();
    breakpoint_match_address = 16'h1230;
    force_tag_select = 1'b1;
    i_cpu_bus_model.cycle(16'h1230, 1'b1, 8'h11, 1'b0, 1'b0);
    chk(force_break, 1'b0);
    breakpoint_enable = 1'b1;
    i_cpu_bus_model.cycle(16'h1230, 1'b0, 8'h11, 1'b0, 1'b0);
    chk(force_break, 1'b1);
    i_cpu_bus_model.cycle(16'h0300, 1'b1, 8'h22, 1'b0, 1'b0);
    chk(force_break, 1'b1);
    boundary();
    chk(force_break, 1'b0);
    force_tag_select = 1'b0;
    i_cpu_bus_model.cycle(16'h1230, 1'b1, 8'h9d, 1'b1, 1'b0);
    chk(tag_break, 1'b1);
    i_cpu_bus_model.cycle(16'h1230, 1'b1, 8'h9d, 1'b0, 1'b0);
    chk({tag_break, force_break}, 2'b00);
    breakpoint_enable = 1'b0;
  endtask
  // Event-only capture: debug accesses ignored, fill past full, drain.
  task automatic t_event();
    trace_module_enable = 1'b1;
    trig_mode = 4'h3;
    comp_b_value = 16'h4000;
    arm(1'b1);
    chk({armed_flag, comp_a_match_flag, comp_b_match_flag, fifo_valid_count}, 7'h40);
    i_cpu_bus_model.cycle(16'h4000, 1'b1, 8'h77, 1'b0, 1'b1);
    chk(fifo_valid_count, 4'h0);
    for (int i = 0; i < 9; i++)
    begin
      i_cpu_bus_model.cycle(16'h4000, 1'b1, 8'h20 + 8'(i), 1'b0, 1'b0);
      chk(fifo_valid_count, (i < 8) ? 4'(i + 1) : 4'h8);
    end
    for (int i = 0; i < 8; i++)
    begin
      chk({fifo_high_byte_port, fifo_low_byte_port}, 16'h0020 + 16'(i));
      low_read();
    end
  endtask
  // Full mode selects the write bus when A qualifies on writes.
  task automatic t_full();
    trig_mode = 4'h5;
    comp_a_value = 16'h5000;
    comp_b_value = 16'h005a;
    {comp_a_rw_qualify_enable, comp_a_rw_value, brk_enable} = 3'b101;
    arm(1'b1);
    i_cpu_bus_model.cycle(16'h5000, 1'b0, 8'ha5, 1'b0, 1'b0);
    chk(force_break, 1'b0);
    i_cpu_bus_model.cycle(16'h5000, 1'b0, 8'h5a, 1'b0, 1'b0);
    chk(force_break, 1'b1);
    boundary();
    brk_enable = 1'b0;
  endtask
  // Profiling while not armed: low reads push the last fetch address.
  task automatic t_profile();
    arm(1'b0);
    chk(armed_flag, 1'b0);
    i_cpu_bus_model.cycle(16'h2468, 1'b1, 8'h9d, 1'b1, 1'b0);
    repeat (8) low_read();
    chk({fifo_high_byte_port, fifo_low_byte_port}, 16'h2468);
  endtask
  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    chk({force_break, tag_break, armed_flag, fifo_valid_count}, 7'h00);
    t_breakpoint();
    t_event();
    t_full();
    t_profile();
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule
bind debug_breakpoint_trace_fifo debug_trace_properties i_debug_trace_properties (.*);
